// [common/jrle_pkg.sv]
// constants and types shared by the jump, return and load executor
package jrle_pkg;
	localparam int          ADDR_W    = 8;
	localparam int          PC_W      = 16;
	// flag register, system mode and condition code bit positions
	localparam int          FL_C      = 7;
	localparam int          FL_Z      = 6;
	localparam int          FL_S      = 5;
	localparam int          FL_V      = 4;
	localparam int          SYM_GIE   = 2;
	localparam int          CC_INV    = 3;
	// reset values
	localparam logic [7:0]  SYM_RST   = 8'h00;
	localparam logic [7:0]  FL_RST    = 8'h00;
	localparam logic [7:0]  SP_RST    = 8'h00;
	localparam logic [15:0] PC_RST    = 16'h0000;
	// opcodes and opcode nibbles
	localparam logic [7:0]  OP_INTERRUPT_RETURN   = 8'hBF;
	localparam logic [7:0]  OP_JP_IND = 8'h30;
	localparam logic [3:0]  NB_JP_CC  = 4'hD;
	localparam logic [3:0]  NB_JR     = 4'hB;
	localparam logic [3:0]  NB_LD_IM  = 4'hC;
	localparam logic [3:0]  NB_LD_RR  = 4'h8;
	localparam logic [3:0]  NB_LD_RW  = 4'h9;
	localparam logic [7:0]  OP_LD_C7  = 8'hC7;
	localparam logic [7:0]  OP_LD_D7  = 8'hD7;
	localparam logic [7:0]  OP_LD_E4  = 8'hE4;
	localparam logic [7:0]  OP_LD_E5  = 8'hE5;
	localparam logic [7:0]  OP_LD_E6  = 8'hE6;
	localparam logic [7:0]  OP_LD_D6  = 8'hD6;
	localparam logic [7:0]  OP_LD_F5  = 8'hF5;
	localparam logic [7:0]  OP_LD_87  = 8'h87;
	localparam logic [7:0]  OP_LD_97  = 8'h97;
	// condition codes with fixed meaning
	localparam logic [3:0]  CC_NEVER  = 4'h0;
	localparam logic [3:0]  CC_ALWAYS = 4'h8;
	// timing counts in instruction clocks
	localparam logic [3:0]  CYC_INTERRUPT_RETURN  = 4'hA;
	localparam logic [3:0]  CYC_JP    = 4'h8;
	localparam logic [3:0]  CYC_JR    = 4'h6;
	localparam logic [3:0]  CYC_LD_S  = 4'h4;
	localparam logic [3:0]  CYC_LD_L  = 4'h6;
	localparam logic [3:0]  CNT_START = 4'h1;
	localparam logic [3:0]  CNT_STEP  = 4'h1;
	// lengths and stack steps
	localparam logic [15:0] LEN2      = 16'h0002;
	localparam logic [15:0] LEN3      = 16'h0003;
	localparam logic [7:0]  SP_INC_FL = 8'h01;
	localparam logic [7:0]  SP_INC_PC = 8'h02;
	localparam logic [7:0]  PAIR_NEXT = 8'h01;

	typedef enum logic [2:0] {K_LD, K_JPCC, K_JPIND, K_JR, K_INTERRUPT_RETURN} kind_t;
	typedef enum logic [3:0] {ST_IDLE, ST_SRC_PTR, ST_SRC_VAL, ST_DST_PTR, ST_WRITE,
		ST_POP_FL, ST_POP_PCH, ST_POP_PCL, ST_JP_HI, ST_JP_LO, ST_WAIT} step_t;

	function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] fl);
		logic c;
		logic z;
		logic s;
		logic v;
		logic b;
		c = fl[FL_C];
		z = fl[FL_Z];
		s = fl[FL_S];
		v = fl[FL_V];
		unique case (cc[2:0])
			3'h0: b = 1'b0;
			3'h1: b = s ^ v;
			3'h2: b = z | (s ^ v);
			3'h3: b = c | z;
			3'h4: b = v;
			3'h5: b = s;
			3'h6: b = z;
			3'h7: b = c;
		endcase
		return b ^ cc[CC_INV];
	endfunction : cond_true
endpackage : jrle_pkg

// [src/jrle_exec.sv]
// executor for interrupt return, absolute and relative jump and register load
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - return pops flags at stack top, stack+1, then program counter, stack+2.
// - interrupt return sets the global interrupt enable bit, bit 2 of mode.
// - conditional absolute jump loads the target when true, else falls through.
// - indirect absolute jump loads pc from the named register pair.
// - conditional absolute jump is three bytes, indirect form is two bytes.
// - conditional jump first byte is condition plus nibble D; indirect is 30; 8 cycles.
// - relative jump adds signed displacement when true, else falls through.
// - displacement is signed, from 128 back to 127 forward.
// - relative jump base is the address after the jump instruction.
// - relative jump is two bytes, condition plus nibble B, six cycles.
// - load copies source to destination, source left unchanged.
// - jumps and loads leave every flag unchanged.
// - with global enable clear, pending requests are not serviced.
module jrle_exec (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	// instruction issue
	input  wire logic                        instr_valid,
	input  wire logic [7:0]                  instr_b0,
	input  wire logic [7:0]                  instr_b1,
	input  wire logic [7:0]                  instr_b2,
	input  wire logic [jrle_pkg::ADDR_W-1:0] wreg_base,
	// updates from other instructions
	input  wire logic                        flags_load,
	input  wire logic [7:0]                  flags_in,
	input  wire logic                        gie_set,
	input  wire logic                        gie_clear,
	input  wire logic                        irq_pending,
	// register file port
	input  wire logic [7:0]                  mem_rdata,
	output logic      [jrle_pkg::ADDR_W-1:0] mem_addr_r,
	output logic      [7:0]                  mem_wdata_r,
	output logic                             mem_rd_r,
	output logic                             mem_wr_r,
	// core state
	output logic      [jrle_pkg::PC_W-1:0]   pc_r,
	output logic      [jrle_pkg::ADDR_W-1:0] sp_r,
	output logic      [7:0]                  flags_r,
	output logic      [7:0]                  sym_r,
	output logic                             irq_service_r,
	output logic                             busy_r,
	output logic                             done_r
);
	import jrle_pkg::*;

	// ----------------------------------------
	// executor state
	// ----------------------------------------
	step_t       step_r,  step_nxt;
	kind_t       kind_r,  kind_nxt;
	logic        ph_r,    ph_nxt;
	logic [3:0]  cnt_r,   cnt_nxt;
	logic [3:0]  cyc_r,   cyc_nxt;
	logic [7:0]  src_a_r, src_a_nxt;
	logic [7:0]  dst_a_r, dst_a_nxt;
	logic        dst_p_r, dst_p_nxt;
	logic [7:0]  off_r,   off_nxt;
	logic [7:0]  val_r,   val_nxt;
	logic [15:0] tgt_r,   tgt_nxt;
	logic        taken_r, taken_nxt;
	logic [15:0] pc0_r,   pc0_nxt;
	logic [7:0]  sp0_r,   sp0_nxt;
	logic [7:0]  op1_r,   op1_nxt;
	logic [7:0]  op2_r,   op2_nxt;
	logic [3:0]  cc_r,    cc_nxt;
	logic [7:0]  addr_nxt;
	logic [7:0]  wdata_nxt;
	logic        rd_nxt;
	logic        wr_nxt;
	logic [15:0] pc_nxt;
	logic [7:0]  sp_nxt;
	logic [7:0]  flags_nxt;
	logic [7:0]  sym_nxt;
	logic        busy_nxt;
	logic        done_nxt;
	logic        irq_nxt;
	logic        legal_c;
	logic        fin_c;
	logic        cond_c;
	step_t       first_c;
	logic [3:0]  wr_c;

	always_comb begin
		step_nxt  = step_r;
		kind_nxt  = kind_r;
		ph_nxt    = 1'b0;
		cnt_nxt   = cnt_r;
		cyc_nxt   = cyc_r;
		src_a_nxt = src_a_r;
		dst_a_nxt = dst_a_r;
		dst_p_nxt = dst_p_r;
		off_nxt   = off_r;
		val_nxt   = val_r;
		tgt_nxt   = tgt_r;
		taken_nxt = taken_r;
		pc0_nxt   = pc0_r;
		sp0_nxt   = sp0_r;
		op1_nxt   = op1_r;
		op2_nxt   = op2_r;
		cc_nxt    = cc_r;
		addr_nxt  = mem_addr_r;
		wdata_nxt = mem_wdata_r;
		rd_nxt    = 1'b0;
		wr_nxt    = 1'b0;
		pc_nxt    = pc_r;
		sp_nxt    = sp_r;
		flags_nxt = flags_r;
		sym_nxt   = sym_r;
		busy_nxt  = busy_r;
		done_nxt  = 1'b0;
		legal_c   = 1'b1;
		first_c   = ST_SRC_VAL;
		wr_c      = wreg_base[7:4];
		cond_c    = cond_true(instr_b0[7:4], flags_r);
		fin_c     = cnt_r >= (cyc_r - CNT_STEP);
		// other instructions may load flags, never while busy
		if (flags_load && !busy_r) begin
			flags_nxt = flags_in;
		end
		if (gie_clear) begin
			sym_nxt[SYM_GIE] = 1'b0;
		end
		if (gie_set) begin
			sym_nxt[SYM_GIE] = 1'b1;
		end
		if (busy_r) begin
			cnt_nxt = cnt_r + CNT_STEP;
		end
		unique case (step_r)
			ST_IDLE: begin
				kind_nxt  = K_LD;
				cyc_nxt   = CYC_LD_S;
				tgt_nxt   = pc_r + LEN2;
				dst_p_nxt = 1'b0;
				off_nxt   = 8'h00;
				taken_nxt = 1'b0;
				src_a_nxt = instr_b1;
				dst_a_nxt = {wr_c, instr_b0[7:4]};
				if (instr_b0 == OP_INTERRUPT_RETURN) begin
					kind_nxt = K_INTERRUPT_RETURN;
					cyc_nxt  = CYC_INTERRUPT_RETURN;
					first_c  = ST_POP_FL;
				end else if (instr_b0 == OP_JP_IND) begin
					kind_nxt  = K_JPIND;
					cyc_nxt   = CYC_JP;
					dst_a_nxt = instr_b1;
					first_c   = ST_JP_HI;
				end else if (instr_b0[3:0] == NB_JP_CC) begin
					kind_nxt  = K_JPCC;
					cyc_nxt   = CYC_JP;
					taken_nxt = cond_c;
					tgt_nxt   = cond_c ? {instr_b1, instr_b2} : pc_r + LEN3;
					first_c   = ST_WAIT;
				end else if (instr_b0[3:0] == NB_JR) begin
					kind_nxt  = K_JR;
					cyc_nxt   = CYC_JR;
					taken_nxt = cond_c;
					tgt_nxt   = pc_r + LEN2 + (cond_c ? {{8{instr_b1[7]}}, instr_b1} : 16'h0000);
					first_c   = ST_WAIT;
				end else if (instr_b0[3:0] == NB_LD_IM) begin
					val_nxt = instr_b1;
					first_c = ST_WRITE;
				end else if (instr_b0[3:0] == NB_LD_RR) begin
					first_c = ST_SRC_VAL;
				end else if (instr_b0[3:0] == NB_LD_RW) begin
					src_a_nxt = {wr_c, instr_b0[7:4]};
					dst_a_nxt = instr_b1;
				end else begin
					// long load forms, plus the two-byte C7 and D7 forms, which are given four cycles but run six
					cyc_nxt   = CYC_LD_L;
					tgt_nxt   = pc_r + LEN3;
					src_a_nxt = instr_b1;
					dst_a_nxt = instr_b2;
					unique case (instr_b0)
						OP_LD_C7: begin
							cyc_nxt   = CYC_LD_S;
							tgt_nxt   = pc_r + LEN2;
							src_a_nxt = {wr_c, instr_b1[3:0]};
							dst_a_nxt = {wr_c, instr_b1[7:4]};
							first_c   = ST_SRC_PTR;
						end
						OP_LD_D7: begin
							cyc_nxt   = CYC_LD_S;
							tgt_nxt   = pc_r + LEN2;
							src_a_nxt = {wr_c, instr_b1[3:0]};
							dst_a_nxt = {wr_c, instr_b1[7:4]};
							dst_p_nxt = 1'b1;
						end
						OP_LD_E4: first_c = ST_SRC_VAL;
						OP_LD_E5: first_c = ST_SRC_PTR;
						OP_LD_E6, OP_LD_D6: begin
							dst_a_nxt = instr_b1;
							val_nxt   = instr_b2;
							dst_p_nxt = (instr_b0 == OP_LD_D6);
							first_c   = (instr_b0 == OP_LD_D6) ? ST_DST_PTR : ST_WRITE;
						end
						OP_LD_F5: dst_p_nxt = 1'b1;
						OP_LD_87: begin
							src_a_nxt = {wr_c, instr_b1[3:0]};
							dst_a_nxt = {wr_c, instr_b1[7:4]};
							off_nxt   = instr_b2;
							first_c   = ST_SRC_PTR;
						end
						OP_LD_97: begin
							src_a_nxt = {wr_c, instr_b1[7:4]};
							dst_a_nxt = {wr_c, instr_b1[3:0]};
							off_nxt   = instr_b2;
							dst_p_nxt = 1'b1;
						end
						default: legal_c = 1'b0;
					endcase
				end
				// unknown opcodes are not taken and leave busy low
				if (instr_valid && legal_c) begin
					step_nxt = first_c;
					busy_nxt = 1'b1;
					cnt_nxt  = CNT_START;
					pc0_nxt  = pc_r;
					sp0_nxt  = sp_r;
					op1_nxt  = instr_b1;
					op2_nxt  = instr_b2;
					cc_nxt   = instr_b0[7:4];
				end
			end
			ST_SRC_PTR: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = src_a_r;
					ph_nxt   = 1'b1;
				end else begin
					src_a_nxt = mem_rdata + off_r;
					step_nxt  = ST_SRC_VAL;
				end
			end
			ST_SRC_VAL: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = src_a_r;
					ph_nxt   = 1'b1;
				end else begin
					val_nxt  = mem_rdata;
					step_nxt = dst_p_r ? ST_DST_PTR : ST_WRITE;
				end
			end
			ST_DST_PTR: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = dst_a_r;
					ph_nxt   = 1'b1;
				end else begin
					dst_a_nxt = mem_rdata + off_r;
					step_nxt  = ST_WRITE;
				end
			end
			ST_WRITE: begin
				// the only write of a load goes to the destination
				wr_nxt    = 1'b1;
				addr_nxt  = dst_a_r;
				wdata_nxt = val_r;
				step_nxt  = ST_WAIT;
			end
			ST_POP_FL: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = sp_r;
					ph_nxt   = 1'b1;
				end else begin
					flags_nxt = mem_rdata;
					sp_nxt    = sp_r + SP_INC_FL;
					step_nxt  = ST_POP_PCH;
				end
			end
			ST_POP_PCH: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = sp_r;
					ph_nxt   = 1'b1;
				end else begin
					tgt_nxt[15:8] = mem_rdata;
					step_nxt      = ST_POP_PCL;
				end
			end
			ST_POP_PCL: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = sp_r + PAIR_NEXT;
					ph_nxt   = 1'b1;
				end else begin
					tgt_nxt[7:0]     = mem_rdata;
					sp_nxt           = sp_r + SP_INC_PC;
					sym_nxt[SYM_GIE] = 1'b1;
					step_nxt         = ST_WAIT;
				end
			end
			ST_JP_HI: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = dst_a_r;
					ph_nxt   = 1'b1;
				end else begin
					tgt_nxt[15:8] = mem_rdata;
					step_nxt      = ST_JP_LO;
				end
			end
			ST_JP_LO: begin
				if (!ph_r) begin
					rd_nxt   = 1'b1;
					addr_nxt = dst_a_r + PAIR_NEXT;
					ph_nxt   = 1'b1;
				end else begin
					tgt_nxt[7:0] = mem_rdata;
					step_nxt     = ST_WAIT;
				end
			end
			ST_WAIT: ;
			default: step_nxt = ST_IDLE;
		endcase
		// short loads may finish in the write cycle itself
		if ((step_r == ST_WAIT || step_r == ST_WRITE) && fin_c) begin
			step_nxt = ST_IDLE;
			busy_nxt = 1'b0;
			done_nxt = 1'b1;
			pc_nxt   = tgt_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_r      <= ST_IDLE;
			kind_r      <= K_LD;
			ph_r        <= 1'b0;
			cnt_r       <= 4'h0;
			cyc_r       <= 4'h0;
			src_a_r     <= 8'h00;
			dst_a_r     <= 8'h00;
			dst_p_r     <= 1'b0;
			off_r       <= 8'h00;
			val_r       <= 8'h00;
			tgt_r       <= PC_RST;
			taken_r     <= 1'b0;
			pc0_r       <= PC_RST;
			sp0_r       <= SP_RST;
			op1_r       <= 8'h00;
			op2_r       <= 8'h00;
			cc_r        <= 4'h0;
			mem_addr_r  <= 8'h00;
			mem_wdata_r <= 8'h00;
			mem_rd_r    <= 1'b0;
			mem_wr_r    <= 1'b0;
			pc_r        <= PC_RST;
			sp_r        <= SP_RST;
			flags_r     <= FL_RST;
			sym_r       <= SYM_RST;
			busy_r      <= 1'b0;
			done_r      <= 1'b0;
		end else begin
			step_r      <= step_nxt;
			kind_r      <= kind_nxt;
			ph_r        <= ph_nxt;
			cnt_r       <= cnt_nxt;
			cyc_r       <= cyc_nxt;
			src_a_r     <= src_a_nxt;
			dst_a_r     <= dst_a_nxt;
			dst_p_r     <= dst_p_nxt;
			off_r       <= off_nxt;
			val_r       <= val_nxt;
			tgt_r       <= tgt_nxt;
			taken_r     <= taken_nxt;
			pc0_r       <= pc0_nxt;
			sp0_r       <= sp0_nxt;
			op1_r       <= op1_nxt;
			op2_r       <= op2_nxt;
			cc_r        <= cc_nxt;
			mem_addr_r  <= addr_nxt;
			mem_wdata_r <= wdata_nxt;
			mem_rd_r    <= rd_nxt;
			mem_wr_r    <= wr_nxt;
			pc_r        <= pc_nxt;
			sp_r        <= sp_nxt;
			flags_r     <= flags_nxt;
			sym_r       <= sym_nxt;
			busy_r      <= busy_nxt;
			done_r      <= done_nxt;
		end
	end

	// ----------------------------------------
	// interrupt service gate
	// ----------------------------------------
	// pending bits live in the controller; only the service is held off
	always_comb begin
		irq_nxt = irq_pending && sym_r[SYM_GIE];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_service_r <= 1'b0;
		end else begin
			irq_service_r <= irq_nxt;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_take_jp;
		!busy_r && instr_valid && (instr_b0 == OP_JP_IND || instr_b0[3:0] == NB_JP_CC);
	endsequence
	sequence s_take_jr;
		!busy_r && instr_valid && instr_b0[3:0] == NB_JR;
	endsequence
	sequence s_take_interrupt_return;
		!busy_r && instr_valid && instr_b0 == OP_INTERRUPT_RETURN;
	endsequence
	sequence s_take_jpind;
		!busy_r && instr_valid && instr_b0 == OP_JP_IND;
	endsequence

	a_jp_cycles: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_take_jp |=> busy_r [*7] ##1 (done_r && !busy_r))
		else $error("absolute jump did not finish in 8 cycles");
	a_jr_cycles: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_take_jr |=> busy_r [*5] ##1 (done_r && !busy_r))
		else $error("relative jump did not finish in 6 cycles");
	a_interrupt_return_stack: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_take_interrupt_return |=> busy_r [*8] ##1 busy_r ##1 (done_r && sp_r == sp0_r + SP_INC_FL + SP_INC_PC))
		else $error("interrupt return stack pointer wrong");
	a_interrupt_return_gie: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_r && kind_r == K_INTERRUPT_RETURN |-> sym_r[SYM_GIE])
		else $error("global enable not set after return");
	a_jpcc_pc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_r && kind_r == K_JPCC |-> pc_r == (taken_r ? {op1_r, op2_r} : pc0_r + LEN3))
		else $error("conditional jump target wrong");
	a_jr_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_r && kind_r == K_JR |->
		pc_r == pc0_r + LEN2 + (taken_r ? {{8{op1_r[7]}}, op1_r} : 16'h0000))
		else $error("relative jump target wrong");
	a_jpind_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_take_jpind |=> ##1 (mem_rd_r && mem_addr_r == op1_r)
		##2 (mem_rd_r && mem_addr_r == op1_r + PAIR_NEXT))
		else $error("register pair read order wrong");
	a_flags_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		busy_r && kind_r != K_INTERRUPT_RETURN |=> $stable(flags_r))
		else $error("flags changed by jump or load");
	a_load_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mem_wr_r |-> kind_r == K_LD && mem_addr_r == dst_a_r && mem_wdata_r == val_r ##1 !mem_wr_r)
		else $error("load wrote wrong place or twice");
	a_irq_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!sym_r[SYM_GIE] |=> !irq_service_r)
		else $error("interrupt serviced while disabled");
	a_cc_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_r && (kind_r == K_JR || kind_r == K_JPCC) && (cc_r == CC_ALWAYS || cc_r == CC_NEVER)
		|-> taken_r == (cc_r == CC_ALWAYS))
		else $error("fixed condition code evaluated wrong");
endmodule : jrle_exec
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the jump, return and load executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import jrle_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        sys_clk;
	logic        rst_n;
	logic        instr_valid, flags_load, gie_set, gie_clear, irq_pending;
	logic [7:0]  instr_b0, instr_b1, instr_b2, wreg_base, flags_in, mem_rdata;
	logic [7:0]  mem_addr_r, mem_wdata_r, sp_r, flags_r, sym_r;
	logic        mem_rd_r, mem_wr_r, irq_service_r, busy_r, done_r;
	logic [15:0] pc_r;
	logic [7:0]  mem [256];
	logic [31:0] seed;
	logic [15:0] exp_pc;
	logic [7:0]  exp_sp, exp_fl, exp_sym;
	int          n_errors;
	int          checked;

	jrle_exec DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_b0(instr_b0),
		.instr_b1(instr_b1), .instr_b2(instr_b2), .wreg_base(wreg_base), .flags_load(flags_load),
		.flags_in(flags_in), .gie_set(gie_set), .gie_clear(gie_clear), .irq_pending(irq_pending),
		.mem_rdata(mem_rdata), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rd_r(mem_rd_r),
		.mem_wr_r(mem_wr_r), .pc_r(pc_r), .sp_r(sp_r), .flags_r(flags_r), .sym_r(sym_r),
		.irq_service_r(irq_service_r), .busy_r(busy_r), .done_r(done_r)
	);

	// ----------------------------------------
	// clock and register file
	// ----------------------------------------
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	// combinational read, as the executor expects it
	assign mem_rdata = mem[mem_addr_r];
	always @(posedge sys_clk) begin
		if (mem_wr_r === 1'b1) begin
			mem[mem_addr_r] <= mem_wdata_r;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// own reading of the condition table, kept apart from the design's
	function automatic logic cc_ok(input logic [3:0] cc, input logic [7:0] f);
		logic r;
		case (cc[2:0])
			3'h0: r = 1'b0;
			3'h1: r = f[5] ^ f[4];
			3'h2: r = f[6] | (f[5] ^ f[4]);
			3'h3: r = f[7] | f[6];
			3'h4: r = f[4];
			3'h5: r = f[5];
			3'h6: r = f[6];
			default: r = f[7];
		endcase
		return r ^ cc[3];
	endfunction : cc_ok

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checked++;
		if (seen !== expv) begin
			n_errors++;
			$display("Error t=%0t seen=%h expected=%h", $time, seen, expv);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic setfl(input logic [7:0] v);
		@(negedge sys_clk);
		flags_load = 1'b1;
		flags_in   = v;
		@(negedge sys_clk);
		flags_load = 1'b0;
		exp_fl     = v;
	endtask : setfl

	// offer one instruction, count clocks to completion, then compare core state
	task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
			input int n, input logic [15:0] npc);
		int k;
		@(negedge sys_clk);
		instr_valid = 1'b1;
		instr_b0    = b0;
		instr_b1    = b1;
		instr_b2    = b2;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		// the take cycle is the first of the instruction's cycles
		k = 1;
		do begin
			@(posedge sys_clk);
			k++;
			@(negedge sys_clk);
		end while (done_r !== 1'b1 && k < 20);
		check(k, n);
		check(pc_r, npc);
		check(flags_r, exp_fl);
		check(sp_r, exp_sp);
		check(sym_r, exp_sym);
		check(busy_r, 1'b0);
		exp_pc = npc;
	endtask : run

	// ----------------------------------------
	// watchdog, well beyond the expected run
	// ----------------------------------------
	initial begin
		#(20 * 6000);
		n_errors++;
		wrap_up();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] t;
		logic [7:0]  a, b, d, f, val, sa, dst, b0;
		logic [3:0]  cc, n;
		int          m;
		n_errors = 0;
		checked = 0;
		seed = 32'h0000_0028;
		rst_n = 1'b0;
		{instr_valid, flags_load, gie_set, gie_clear, irq_pending} = 5'h00;
		{instr_b0, instr_b1, instr_b2, wreg_base, flags_in} = 40'h00_0000_0000;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(rnd());
		end
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		{exp_pc, exp_sp, exp_fl, exp_sym} = 40'h00_0000_0000;
		check(pc_r, 16'h0000);
		check(sp_r, 8'h00);
		check(sym_r, 8'h00);
		// both jump kinds over every condition code, with displacements 7F, 80 and FE first
		for (int i = 0; i < 32; i++) begin
			cc = i[3:0];
			setfl(8'(rnd()));
			t = 16'(rnd());
			run({cc, NB_JP_CC}, t[15:8], t[7:0], 8, cc_ok(cc, exp_fl) ? t : exp_pc + 16'h0003);
			d = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : (i == 2) ? 8'hFE : 8'(rnd());
			t = cc_ok(cc, exp_fl) ? {{8{d[7]}}, d} : 16'h0000;
			run({cc, NB_JR}, d, 8'(rnd()), 6, exp_pc + 16'h0002 + t);
		end
		// register-pair indirect jump
		for (int i = 0; i < 8; i++) begin
			a = 8'(rnd() & 32'h0000_00FE);
			mem[a] = 8'(rnd());
			mem[a + 8'h01] = 8'(rnd());
			run(OP_JP_IND, a, 8'(rnd()), 8, {mem[a], mem[a + 8'h01]});
		end
		// loads across five addressing combinations
		for (int i = 0; i < 40; i++) begin
			m = i % 5;
			setfl(8'(rnd()));
			wreg_base = 8'(rnd());
			n = 4'(rnd());
			a = 8'(rnd());
			b = 8'(rnd());
			case (m)
				0: begin b0 = {n, NB_LD_IM}; dst = {wreg_base[7:4], n}; sa = dst; val = a; end
				1: begin b0 = {n, NB_LD_RR}; dst = {wreg_base[7:4], n}; sa = a; val = mem[a]; end
				2: begin b0 = {n, NB_LD_RW}; dst = a; sa = {wreg_base[7:4], n}; val = mem[sa]; end
				3: begin b0 = OP_LD_E4; dst = b; sa = a; val = mem[a]; end
				default: begin b0 = OP_LD_E6; dst = a; sa = a; val = b; end
			endcase
			run(b0, a, b, (m < 3) ? 4 : 6, exp_pc + ((m < 3) ? 16'h0002 : 16'h0003));
			@(negedge sys_clk);
			check(mem[dst], val);
			check(mem[sa], val);
		end
		// interrupt gating and return from interrupt
		irq_pending = 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(negedge sys_clk);
			gie_clear = 1'b1;
			@(negedge sys_clk);
			gie_clear = 1'b0;
			exp_sym = 8'h00;
			repeat (3) @(negedge sys_clk);
			check(irq_service_r, 1'b0);
			if (i == 0) begin
				gie_set = 1'b1;
				@(negedge sys_clk);
				gie_set = 1'b0;
				repeat (2) @(negedge sys_clk);
				check(irq_service_r, 1'b1);
				gie_clear = 1'b1;
				@(negedge sys_clk);
				gie_clear = 1'b0;
			end
			setfl(8'(rnd()));
			mem[exp_sp] = 8'(rnd());
			mem[exp_sp + 8'h01] = 8'(rnd());
			mem[exp_sp + 8'h02] = 8'(rnd());
			f = mem[exp_sp];
			t = {mem[exp_sp + 8'h01], mem[exp_sp + 8'h02]};
			exp_fl = f;
			exp_sp = exp_sp + 8'h03;
			exp_sym = 8'h04;
			run(OP_INTERRUPT_RETURN, 8'(rnd()), 8'(rnd()), 10, t);
			check(irq_service_r, 1'b1);
		end
		// an opcode outside the decoded set is ignored
		@(negedge sys_clk);
		instr_valid = 1'b1;
		instr_b0 = 8'h00;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		check(busy_r, 1'b0);
		check(pc_r, exp_pc);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
